// >>> inc/vgis_regs.svh
// Register offsets, field positions and reset values of the status block.
// Assumes it is included by bare name from the package and the design files.
`ifndef VGIS_REGS_SVH
`define VGIS_REGS_SVH

// Register offsets on the device register port.
`define VGIS_ADDR_VMON       8'h62
`define VGIS_ADDR_SUMMARY    8'h63
`define VGIS_ADDR_PIN_LOW    8'h64
`define VGIS_ADDR_LIVE       8'h6A
`define VGIS_ADDR_LEVEL_LOW  8'h6B
`define VGIS_ADDR_LEVEL_HIGH 8'h6C

// Reset value shared by every register of the block.
`define VGIS_RST_BYTE        8'h00

// Monitor flag register bit positions.
`define VGIS_B_RES_TWO       7
`define VGIS_B_UNDER_TWO     6
`define VGIS_B_OVER_TWO      5
`define VGIS_B_RES_ONE       4
`define VGIS_B_UNDER_ONE     3
`define VGIS_B_OVER_ONE      2
`define VGIS_B_UNDER_ANA     1
`define VGIS_B_OVER_ANA      0

// Pin summary register layout.
`define VGIS_B_SUMMARY       3
`define VGIS_B_PIN_TEN       1
`define VGIS_B_PIN_NINE      0
`define VGIS_SUM_RSV_MASK    8'hF4

// Field widths.
`define VGIS_VMON_W          8
`define VGIS_PIN_LOW_W       8
`define VGIS_PIN_HIGH_W      2
`define VGIS_PIN_W           10
`define VGIS_MON_W           3
`define VGIS_RES_W           2

`endif

// >>> inc/vgis_pkg.sv
// Types shared by the status block files.
// Assumes the register header sits in the include path.
`include "vgis_regs.svh"

package vgis_pkg;

    // One register byte as seen on the register port.
    typedef logic [7:0] vgis_byte_t;

    // Selector for the register that an access hits.
    typedef enum logic [6:0]
    {
        VGIS_SEL_VMON    = 7'h01,
        VGIS_SEL_SUMMARY = 7'h02,
        VGIS_SEL_PIN_LOW = 7'h04,
        VGIS_SEL_LIVE    = 7'h08,
        VGIS_SEL_LVL_LO  = 7'h10,
        VGIS_SEL_LVL_HI  = 7'h20,
        VGIS_SEL_NONE    = 7'h40
    } vgis_sel_t;

endpackage

// >>> inc/vgis_flag_if.sv
// Carrier between the status top and one bank of sticky flags.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps

interface vgis_flag_if #(parameter int W = 8);
    logic [W-1:0] set;    // Set events, one per flag: held levels for the monitors, one-cycle pulses for the pins.
    logic [W-1:0] clr;    // One-cycle clear pulses from a write of ones.
    logic [W-1:0] flags;  // Present sticky flag values.

    // The bank holds the flags.
    modport bank (input set, input clr, output flags);
    // The top feeds events and clears.
    modport user (output set, output clr, input flags);
endinterface

// >>> core/vgis_flag_bank.sv
// One bank of sticky flags with write-one-to-clear behaviour.
// Assumes set and clr arrive on the bank clock, already synchronised.
`timescale 1ns/100ps
`include "vgis_regs.svh"

module vgis_flag_bank #(parameter int W = 8)
(
    input  wire logic  ref_clk_i,
    input  wire logic  rst_n_i,
    vgis_flag_if.bank  fl
);

    logic [W-1:0] flags_q;  // Sticky flag storage.
    logic [W-1:0] flags_d;  // Next flag values.

    // A set in the clear cycle wins, so no event is ever lost.
    always_comb
    begin
        flags_d = (flags_q & ~fl.clr) | fl.set;
    end

    // Synchronous reset clears every flag.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            flags_q <= W'(`VGIS_RST_BYTE);
        end
        else
        begin
            flags_q <= flags_d;
        end
    end

    assign fl.flags = flags_q;

endmodule

// >>> core/vgis_top.sv
// Latched status for three voltage monitors and ten pins, with its registers.
// Assumes raw comparator and pin levels are asynchronous; pin events are
// one-cycle pulses from edge logic on this clock.
`timescale 1ns/100ps
`include "vgis_regs.svh"

module vgis_top
(
    input  wire logic        ref_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic [2:0]  mon_under_raw_i,
    input  wire logic [2:0]  mon_over_raw_i,
    input  wire logic [1:0]  mon_residual_raw_i,
    input  wire logic        voltage_check_raw_i,
    input  wire logic [9:0]  pin_level_raw_i,
    input  wire logic [9:0]  pin_event_i,
    output logic             irq_o
);

    localparam int SW = 2 * `VGIS_MON_W + `VGIS_RES_W + 1 + `VGIS_PIN_W;

    logic [SW-1:0]              sync1_q;   // First stage, read by second only.
    logic [SW-1:0]              sync2_q;   // Second stage, safe for logic.
    logic [`VGIS_MON_W-1:0]     under_s;   // Synced undervoltage levels.
    logic [`VGIS_MON_W-1:0]     over_s;    // Synced overvoltage levels.
    logic [`VGIS_RES_W-1:0]     res_s;     // Synced residual levels.
    logic                       chk_s;     // Synced voltage check window.
    logic [`VGIS_PIN_W-1:0]     lvl_s;     // Synced pin levels.
    vgis_pkg::vgis_byte_t       live_q;    // Live comparator status.
    vgis_pkg::vgis_byte_t       live_d;
    vgis_pkg::vgis_byte_t       rsv_q;     // Reserved summary bits.
    vgis_pkg::vgis_byte_t       rsv_d;
    vgis_pkg::vgis_byte_t       rdata_q;   // Registered read data.
    vgis_pkg::vgis_byte_t       rdata_d;
    logic                       irq_q;     // Registered interrupt request.
    logic                       irq_d;
    vgis_pkg::vgis_sel_t        sel;       // Decoded register selector.
    logic                       summary;   // Pin 1-8 pending summary.

    vgis_flag_if #(.W(`VGIS_VMON_W))     vmon_if ();
    vgis_flag_if #(.W(`VGIS_PIN_LOW_W))  low_if ();
    vgis_flag_if #(.W(`VGIS_PIN_HIGH_W)) high_if ();

    // Address decode, used by both the write and the read path.
    function automatic vgis_pkg::vgis_sel_t decode(input logic [7:0] a);
        case (a)
            `VGIS_ADDR_VMON:       decode = vgis_pkg::VGIS_SEL_VMON;
            `VGIS_ADDR_SUMMARY:    decode = vgis_pkg::VGIS_SEL_SUMMARY;
            `VGIS_ADDR_PIN_LOW:    decode = vgis_pkg::VGIS_SEL_PIN_LOW;
            `VGIS_ADDR_LIVE:       decode = vgis_pkg::VGIS_SEL_LIVE;
            `VGIS_ADDR_LEVEL_LOW:  decode = vgis_pkg::VGIS_SEL_LVL_LO;
            `VGIS_ADDR_LEVEL_HIGH: decode = vgis_pkg::VGIS_SEL_LVL_HI;
            default:               decode = vgis_pkg::VGIS_SEL_NONE;
        endcase
    endfunction

    // Comparators and pin levels are asynchronous, so all pass two flops.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= '0;
            sync2_q <= '0;
        end
        else
        begin
            sync1_q <= {voltage_check_raw_i, mon_residual_raw_i, mon_over_raw_i,
                        mon_under_raw_i, pin_level_raw_i};
            sync2_q <= sync1_q;
        end
    end

    // Slices of the second stage; the first stage is never looked at.
    assign {chk_s, res_s, over_s, under_s, lvl_s} = sync2_q;
    assign sel = decode(reg_addr_i);

    // Monitor flag events; residual only counts inside the check window.
    always_comb
    begin
        vmon_if.set = '0;
        vmon_if.set[`VGIS_B_RES_TWO]   = chk_s & res_s[1];
        vmon_if.set[`VGIS_B_RES_ONE]   = chk_s & res_s[0];
        vmon_if.set[`VGIS_B_UNDER_TWO] = under_s[2];
        vmon_if.set[`VGIS_B_UNDER_ONE] = under_s[1];
        vmon_if.set[`VGIS_B_UNDER_ANA] = under_s[0];
        vmon_if.set[`VGIS_B_OVER_TWO]  = over_s[2];
        vmon_if.set[`VGIS_B_OVER_ONE]  = over_s[1];
        vmon_if.set[`VGIS_B_OVER_ANA]  = over_s[0];
        // Pin n lands at bit n-1; pins 9 and 10 go to the summary register.
        low_if.set  = pin_event_i[`VGIS_PIN_LOW_W-1:0];
        high_if.set = pin_event_i[`VGIS_PIN_W-1:`VGIS_PIN_LOW_W];
    end

    // Clears only where a one is written; zeros leave flags alone.
    always_comb
    begin
        vmon_if.clr = '0;
        low_if.clr  = '0;
        high_if.clr = '0;
        if (reg_wr_i)
        begin
            case (sel)
                vgis_pkg::VGIS_SEL_VMON:    vmon_if.clr = reg_wdata_i;
                vgis_pkg::VGIS_SEL_PIN_LOW: low_if.clr  = reg_wdata_i;
                vgis_pkg::VGIS_SEL_SUMMARY:
                    high_if.clr = reg_wdata_i[`VGIS_PIN_HIGH_W-1:0];
                default:                    vmon_if.clr = '0;
            endcase
        end
    end

    vgis_flag_bank #(.W(`VGIS_VMON_W)) u_vmon
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .fl        (vmon_if)
    );

    vgis_flag_bank #(.W(`VGIS_PIN_LOW_W)) u_pin_low
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .fl        (low_if)
    );

    vgis_flag_bank #(.W(`VGIS_PIN_HIGH_W)) u_pin_high
    (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .fl        (high_if)
    );

    // Summary has no storage, so it drops the moment the pin flags clear.
    assign summary = |low_if.flags;

    // Live status, reserved bits, read data and interrupt next values.
    always_comb
    begin
        live_d  = {2'h0, under_s[2], over_s[2], under_s[1], over_s[1],
                   under_s[0], over_s[0]};
        rsv_d   = rsv_q;
        if (reg_wr_i && sel == vgis_pkg::VGIS_SEL_SUMMARY)
        begin
            rsv_d = reg_wdata_i & `VGIS_SUM_RSV_MASK;
        end
        rdata_d = rdata_q;
        if (reg_rd_i)
        begin
            case (sel)
                vgis_pkg::VGIS_SEL_VMON:    rdata_d = vmon_if.flags;
                vgis_pkg::VGIS_SEL_SUMMARY:
                    rdata_d = rsv_q | (8'(summary) << `VGIS_B_SUMMARY)
                              | {6'h00, high_if.flags};
                vgis_pkg::VGIS_SEL_PIN_LOW: rdata_d = low_if.flags;
                vgis_pkg::VGIS_SEL_LIVE:    rdata_d = live_q;
                vgis_pkg::VGIS_SEL_LVL_LO:
                    rdata_d = lvl_s[`VGIS_PIN_LOW_W-1:0];
                vgis_pkg::VGIS_SEL_LVL_HI:
                    rdata_d = {6'h00, lvl_s[`VGIS_PIN_W-1:`VGIS_PIN_LOW_W]};
                default:                    rdata_d = `VGIS_RST_BYTE;
            endcase
        end
        // Follows the flags one cycle later; a trade of latency for a clean flop.
        irq_d = (|vmon_if.flags) | summary | (|high_if.flags);
    end

    // Register stage for the group above.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rst_n_i)
        begin
            live_q  <= `VGIS_RST_BYTE;
            rsv_q   <= `VGIS_RST_BYTE;
            rdata_q <= `VGIS_RST_BYTE;
            irq_q   <= 1'b0;
        end
        else
        begin
            live_q  <= live_d;
            rsv_q   <= rsv_d;
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_o       = irq_q;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_res_set;
        (chk_s && res_s[1]) |=> vmon_if.flags[`VGIS_B_RES_TWO];
    endproperty
    a_res_set: assert property (p_res_set) else $error("residual flag missed");

    property p_under_set;
        under_s[0] |=> vmon_if.flags[`VGIS_B_UNDER_ANA] && live_q[`VGIS_B_UNDER_ANA];
    endproperty
    a_under_set: assert property (p_under_set) else $error("under flag missed");

    property p_over_set;
        over_s[2] |=> vmon_if.flags[`VGIS_B_OVER_TWO];
    endproperty
    a_over_set: assert property (p_over_set) else $error("over flag missed");

    property p_sticky;
        (vmon_if.flags[`VGIS_B_OVER_ANA] && !(reg_wr_i && sel == vgis_pkg::VGIS_SEL_VMON))
            |=> vmon_if.flags[`VGIS_B_OVER_ANA] && live_q[0] == $past(over_s[0]);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag not sticky");

    property p_clear;
        (reg_wr_i && sel == vgis_pkg::VGIS_SEL_PIN_LOW && pin_event_i == 10'h000)
            |=> (low_if.flags & $past(reg_wdata_i)) == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("write one did not clear");

    property p_summary;
        (reg_rd_i && sel == vgis_pkg::VGIS_SEL_SUMMARY)
            |=> reg_rdata_o[`VGIS_B_SUMMARY] == $past(low_if.flags != 8'h00);
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    // Any pin-low write with no pin 1-8 event whose ones cover every pending pin flag must drop the summary.
    property p_auto_clear;
        (low_if.flags != 8'h00 && reg_wr_i && sel == vgis_pkg::VGIS_SEL_PIN_LOW
            && (low_if.flags & ~reg_wdata_i) == 8'h00
            && pin_event_i[`VGIS_PIN_LOW_W-1:0] == 8'h00) |=> !summary;
    endproperty
    a_auto_clear: assert property (p_auto_clear) else $error("summary stuck");

    property p_pin_high;
        pin_event_i[9] |=> high_if.flags[`VGIS_B_PIN_TEN];
    endproperty
    a_pin_high: assert property (p_pin_high) else $error("pin ten flag missed");

    property p_pin_low;
        pin_event_i[0] |=> low_if.flags[0];
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin one flag missed");

    property p_level;
        (reg_rd_i && sel == vgis_pkg::VGIS_SEL_LVL_LO) |=> reg_rdata_o == $past(lvl_s[7:0]);
    endproperty
    a_level: assert property (p_level) else $error("pin level read wrong");

    // Its own disable clause, or the default one would mute it whenever reset is low.
    property p_reset;
        @(posedge ref_clk_i) disable iff (1'b0)
        !rst_n_i |=> (vmon_if.flags == 8'h00 && low_if.flags == 8'h00
            && high_if.flags == 2'h0 && rsv_q == 8'h00 && !irq_o);
    endproperty
    a_reset: assert property (p_reset) else $error("reset values wrong");

    property p_set_wins;
        (pin_event_i[0] && reg_wr_i && sel == vgis_pkg::VGIS_SEL_PIN_LOW && reg_wdata_i[0])
            |=> low_if.flags[0];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("clear beat set");

    property p_irq;
        (summary || high_if.flags != 2'h0) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request missing");

endmodule

// >>> testbench/vgis_host_model.sv
// Host-side model of the device register port: single writes and reads.
// Assumes the device samples its strobes on the rising edge of ref_clk_i.
`timescale 1ns/100ps

module vgis_host_model
(
    input  wire logic       ref_clk_i,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic [7:0]      reg_addr_o,
    output logic [7:0]      reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    // The port is idle at time zero, with no strobe raised.
    initial
    begin
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // One write; a one in the data asks the device to clear that flag.
    // After release the bus shows the inverse, so a stale copy never hides a fault.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b1;
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
    endtask

    // One read; the data is taken one cycle after the strobe edge, where it stands.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b1;
        reg_addr_o <= a;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        reg_addr_o <= ~a;
        @(posedge ref_clk_i);
        #1 d = reg_rdata_i;
    endtask
endmodule

// >>> testbench/vgis_top_test.sv
// Self-checking bench for the latched monitor and pin status block.
// Assumes the host model issues every register access.
`timescale 1ns/100ps
`include "vgis_regs.svh"
`define CHK(g, e) check_val(8'(g), 8'(e))

module vgis_top_test;
    logic       clk   = 1'b0;  // Device clock, 25 MHz.
    logic       rst_n = 1'b0;  // Synchronous active-low reset.
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [2:0] under = 3'h0;  // Comparator inputs, idle when low.
    logic [2:0] over  = 3'h0;
    logic [1:0] res   = 2'h0;
    logic       chk   = 1'b0;  // Voltage check window.
    logic [9:0] lvl   = 10'h000;
    logic [9:0] evt   = 10'h000;
    logic       irq;
    int         bad_count  = 0;
    int         n_compared = 0;
    int         cyc        = 0;
    // One row per monitor case; the last row is a residual outside the check window.
    logic [2:0] t_un[9] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0};
    logic [2:0] t_ov[9] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0};
    logic [1:0] t_rs[9] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h3};
    logic [7:0] t_fl[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h00};
    logic [7:0] t_lv[9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h10, 8'h20, 8'h00, 8'h00};

    vgis_host_model u_host
    (
        .ref_clk_i   (clk),
        .reg_wr_o    (wr),
        .reg_rd_o    (rd),
        .reg_addr_o  (addr),
        .reg_wdata_o (wdata),
        .reg_rdata_i (rdata)
    );

    vgis_top u_dut
    (
        .ref_clk_i           (clk),
        .rst_n_i             (rst_n),
        .reg_wr_i            (wr),
        .reg_rd_i            (rd),
        .reg_addr_i          (addr),
        .reg_wdata_i         (wdata),
        .reg_rdata_o         (rdata),
        .mon_under_raw_i     (under),
        .mon_over_raw_i      (over),
        .mon_residual_raw_i  (res),
        .voltage_check_raw_i (chk),
        .pin_level_raw_i     (lvl),
        .pin_event_i         (evt),
        .irq_o               (irq)
    );

    // Free-running clock, 40 ns period.
    always #20 clk = ~clk;

    // Counts every comparison and reports a mismatch at once.
    task automatic check_val(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // Reads one register and compares it with the expected byte.
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        `CHK(d, e);
    endtask

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // A hang is cut short well past the few hundred cycles the tests need.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            bad_count++;
            end_sim();
        end
    end

    // Main sequence of register accesses and input stimulus.
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`VGIS_ADDR_VMON, 8'h00);
        rdc(`VGIS_ADDR_SUMMARY, 8'h00);
        rdc(`VGIS_ADDR_PIN_LOW, 8'h00);
        `CHK(irq, 1'b0);
        // Each monitor condition is held, checked live, dropped, then found still latched, except the residual outside the check window.
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk);
            under <= t_un[i];
            over  <= t_ov[i];
            res   <= t_rs[i];
            chk   <= (i == 4 || i == 7);
            repeat (5) @(posedge clk);
            rdc(`VGIS_ADDR_LIVE, t_lv[i]);
            @(posedge clk);
            under <= 3'h0;
            over  <= 3'h0;
            res   <= 2'h0;
            chk   <= 1'b0;
            repeat (5) @(posedge clk);
            rdc(`VGIS_ADDR_VMON, t_fl[i]);
            `CHK(irq, t_fl[i] != 8'h00);
            u_host.wr(`VGIS_ADDR_VMON, 8'hFF);
            rdc(`VGIS_ADDR_VMON, 8'h00);
        end
        // One event pulse per pin, back to back with one idle cycle between.
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            evt <= 10'h001 << i;
            @(posedge clk);
            evt <= 10'h000;
        end
        rdc(`VGIS_ADDR_PIN_LOW, 8'hFF);
        rdc(`VGIS_ADDR_SUMMARY, 8'h0B);
        `CHK(irq, 1'b1);
        u_host.wr(`VGIS_ADDR_PIN_LOW, 8'h00);
        u_host.wr(`VGIS_ADDR_SUMMARY, 8'h00);
        rdc(`VGIS_ADDR_PIN_LOW, 8'hFF);
        rdc(`VGIS_ADDR_SUMMARY, 8'h0B);
        u_host.wr(`VGIS_ADDR_PIN_LOW, 8'h0F);
        rdc(`VGIS_ADDR_PIN_LOW, 8'hF0);
        rdc(`VGIS_ADDR_SUMMARY, 8'h0B);
        u_host.wr(`VGIS_ADDR_PIN_LOW, 8'hF0);
        rdc(`VGIS_ADDR_SUMMARY, 8'h03);
        u_host.wr(`VGIS_ADDR_SUMMARY, 8'hF4);
        rdc(`VGIS_ADDR_SUMMARY, 8'hF7);
        u_host.wr(`VGIS_ADDR_SUMMARY, 8'h03);
        rdc(`VGIS_ADDR_SUMMARY, 8'h00);
        `CHK(irq, 1'b0);
        // A pin event lands on the very edge that takes a clearing write.
        fork
            u_host.wr(`VGIS_ADDR_PIN_LOW, 8'h01);
            begin
                @(posedge clk);
                evt <= 10'h001;
                @(posedge clk);
                evt <= 10'h000;
            end
        join
        rdc(`VGIS_ADDR_PIN_LOW, 8'h01);
        u_host.wr(`VGIS_ADDR_PIN_LOW, 8'h01);
        rdc(`VGIS_ADDR_PIN_LOW, 8'h00);
        // Pin levels are readable, leave the flags alone and refuse writes.
        @(posedge clk);
        lvl <= 10'h2A5;
        repeat (4) @(posedge clk);
        rdc(`VGIS_ADDR_LEVEL_LOW, 8'hA5);
        rdc(`VGIS_ADDR_LEVEL_HIGH, 8'h02);
        rdc(`VGIS_ADDR_PIN_LOW, 8'h00);
        u_host.wr(`VGIS_ADDR_LEVEL_LOW, 8'h00);
        rdc(`VGIS_ADDR_LEVEL_LOW, 8'hA5);
        // A reset in mid-run with flags and reserved bits set must clear them all.
        u_host.wr(`VGIS_ADDR_SUMMARY, 8'hF4);
        @(posedge clk);
        evt <= 10'h301;
        @(posedge clk);
        evt <= 10'h000;
        rdc(`VGIS_ADDR_SUMMARY, 8'hFF);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(`VGIS_ADDR_SUMMARY, 8'h00);
        rdc(`VGIS_ADDR_PIN_LOW, 8'h00);
        rdc(`VGIS_ADDR_VMON, 8'h00);
        `CHK(irq, 1'b0);
        rdc(8'h70, 8'h00); // Unmapped offset reads as zero.
        end_sim();
    end
endmodule
